// ---- hw/lpm_pkg.sv ----
// constants and types for the low power mode controller
package lpm_pkg;
   // vector addresses, high byte at even address
   localparam logic [15:0] VEC_TIMEBASE   = 16'hffdc;
   localparam logic [15:0] VEC_ADC        = 16'hffde;
   localparam logic [15:0] VEC_KEYBOARD   = 16'hffe0;
   localparam logic [15:0] VEC_SCI_TX     = 16'hffe2;
   localparam logic [15:0] VEC_SCI_RX     = 16'hffe4;
   localparam logic [15:0] VEC_SCI_ERR    = 16'hffe6;
   localparam logic [15:0] VEC_SPI_TX     = 16'hffe8;
   localparam logic [15:0] VEC_SPI_RX     = 16'hffea;
   localparam logic [15:0] VEC_SECOND_TIMER_OVF   = 16'hffec;
   localparam logic [15:0] VEC_RESERVED   = 16'hffee;
   localparam logic [15:0] VEC_SECOND_TIMER_CH0   = 16'hfff0;
   localparam logic [15:0] VEC_FIRST_TIMER_OVF   = 16'hfff2;
   localparam logic [15:0] VEC_FIRST_TIMER_CH1   = 16'hfff4;
   localparam logic [15:0] VEC_FIRST_TIMER_CH0   = 16'hfff6;
   localparam logic [15:0] VEC_PLL        = 16'hfff8;
   localparam logic [15:0] VEC_IRQ        = 16'hfffa;
   localparam logic [15:0] VEC_SWI        = 16'hfffc;
   localparam logic [15:0] VEC_RESET      = 16'hfffe;
   localparam int          NUM_SRC        = 16;
   localparam int          RESERVED_SRC   = 7;
   // apb register byte offsets
   localparam logic [7:0]  OFF_CONFIG     = 8'h00;
   localparam logic [7:0]  OFF_PLL_CTRL   = 8'h04;
   localparam logic [7:0]  OFF_STATUS     = 8'h08;
   localparam logic [7:0]  OFF_IRQ_ONE    = 8'h0c;
   localparam logic [7:0]  OFF_IRQ_TWO    = 8'h10;
   localparam logic [7:0]  OFF_IRQ_THREE  = 8'h14;
   localparam logic [7:0]  OFF_VECTOR     = 8'h18;
   localparam logic [7:0]  OFF_COMMAND    = 8'h1c;
   // config fields
   localparam int          CFG_STOP_EN    = 0;
   localparam int          CFG_OSC_RUN    = 1;
   localparam int          CFG_LVI_OFF    = 2;
   localparam int          CFG_TBM_OFF    = 3;
   localparam logic [3:0]  CONFIG_RESET   = 4'h0;
   // pll control fields
   localparam int          PLL_SEL        = 0;
   localparam int          PLL_PWR        = 1;
   localparam logic [1:0]  PLL_RESET      = 2'h2;
   // command fields
   localparam int          CMD_BW_CLEAR   = 0;
   localparam int          CMD_COP_CLEAR  = 1;
   // oscillator stabilisation delay
   localparam int          OSC_STAB_NS    = 163840;
   localparam int          CLK_NS         = 40;
   localparam int          OSC_STAB_CYC   = (OSC_STAB_NS + CLK_NS - 1) / CLK_NS;
   // power modes
   typedef enum logic [3:0] {
      LPM_RUN    = 4'b0001,
      LPM_WAIT   = 4'b0010,
      LPM_STOP   = 4'b0100,
      LPM_SETTLE = 4'b1000
   } lpm_state_t;
endpackage

// ---- hw/lpm_vector.sv ----
// fixed priority vector selector over the pending sources
`timescale 1ns/10ps
module lpm_vector (
   input  wire logic [16:1] pending,
   input  wire logic        swi_req,
   output logic             any_pending,
   output logic [15:0]      vector
);
   // address table, index is flag number
   function automatic logic [15:0] vec_of(input int idx);
      logic [15:0] v;
      v = 16'hfffe - 16'(2 * (idx + 1));
      return v;
   endfunction

   // lowest flag number wins, swi above all sources
   always_comb begin
      vector      = lpm_pkg::VEC_RESET;
      any_pending = 1'b0;
      for (int i = lpm_pkg::NUM_SRC; i >= 1; i--) begin
         if (pending[i] && i != lpm_pkg::RESERVED_SRC) begin
            vector      = vec_of(i);
            any_pending = 1'b1;
         end
      end
      if (swi_req) begin
         vector      = lpm_pkg::VEC_SWI;
         any_pending = 1'b1;
      end
   end
endmodule

// ---- hw/lpm_settle.sv ----
// oscillator stabilisation counter after stop exit
`timescale 1ns/10ps
module lpm_settle #(
   parameter int STAB_CYCLES = lpm_pkg::OSC_STAB_CYC
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic start,
   output logic      done
);
   logic [17:0] count;
   logic [17:0] next_count;

   // load on start, count down to zero
   always_comb begin
      next_count = count;
      if (start)
         next_count = 18'(STAB_CYCLES);
      else if (count != 18'h0)
         next_count = count - 18'h1;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         count <= 18'h0;
      else
         count <= next_count;
   end

   assign done = (count == 18'h1);
endmodule

// ---- hw/lpm_control.sv ----
// low power mode controller with apb registers
// Notes on behaviour
// - vectors: high byte at even address, priority rises with address, adc at ffde
// - sci transmit ffe2, receive ffe4, error ffe6
// - spi transmit ffe8, receive ffea
// - second timer overflow ffec, channel 0 fff0, ffee reserved
// - first timer fff2..fff6, pll fff8, irq fffa
// - wait stops cpu clock, bus clock keeps running
// - config bits switch off low voltage inhibit and timebase in wait
// - stop halts cpu clock, and bus clock unless oscillator runs
// - adc runs in wait, its interrupt wakes from wait
// - stop aborts adc conversion, resumes after interrupt exit
// - break stays active in wait, sets break during wait flag
// - break inactive in stop, but break interrupt wakes and sets flag
// - wait clears interrupt mask; stays clear on interrupt exit, set on reset
// - stop clears mask; stays clear on external exit, set on reset
// - cpu clock held off for stabilisation delay after stop exit
// - clock generator active in wait; pll select and power software controlled
// - stop without oscillator run disables oscillator, pll and holds outputs low
// - stop clears pll select, crystal clock then drives core clock
// - stop with oscillator run shuts pll, keeps oscillator
// - stop removes crystal clock from watchdog and clears prescaler
// - stop instruction executes only with stop enable set
// - pending flags 1..16 readable over three status registers, reserved flag 7 always reads zero, reset zero
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
module lpm_control #(
   parameter int STAB_CYCLES = lpm_pkg::OSC_STAB_CYC
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        wait_instr,
   input  wire logic        stop_instr,
   input  wire logic        swi_req,
   input  wire logic [16:1] irq_source,
   input  wire logic        break_irq,
   input  wire logic        ext_irq,
   input  wire logic        vector_taken,
   output logic             cpu_clock_en,
   output logic             bus_clock_en,
   output logic             osc_enable,
   output logic             pll_enable,
   output logic             crystal_clock_en,
   output logic             core_clock_en,
   output logic             clockgen_int_en,
   output logic             core_from_vco,
   output logic             adc_enable,
   output logic             adc_abort,
   output logic             watchdog_clock_en,
   output logic             watchdog_prescaler_clear,
   output logic             watchdog_counter_clear,
   output logic             lvi_enable,
   output logic             timebase_enable,
   output logic             break_enable,
   output logic             interrupt_mask,
   output logic             break_during_wait_flag,
   output logic             wake_pulse,
   output logic [15:0]      vector
);
   logic                    sync1;
   logic                    rst_n;
   logic                    any_pending;
   logic [15:0]             vec_sel;
   logic                    settle_done;
   lpm_pkg::lpm_state_t     state;
   lpm_pkg::lpm_state_t     next_state;
   logic [3:0]              config_bits;
   logic [3:0]              next_config_bits;
   logic [1:0]              pll_ctrl;
   logic [1:0]              next_pll_ctrl;
   logic                    next_mask;
   logic                    next_bw;
   logic                    next_abort;
   logic                    next_presc_clr;
   logic                    next_cop_clr;
   logic                    next_wake;
   logic [15:0]             next_vector;
   logic [31:0]             next_prdata;
   logic [16:1]             pending;
   logic                    wr;
   logic                    rd;
   logic                    wake_wait;
   logic                    wake_stop;
   logic                    stop_ok;
   logic                    settle_start;

   // reset release through two flops
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sync1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         sync1 <= 1'b1;
         rst_n <= sync1;
      end
   end

   assign pending = irq_source & ~(16'h1 << (lpm_pkg::RESERVED_SRC - 1));

   lpm_vector u_vector (
      .pending     (pending),
      .swi_req     (swi_req),
      .any_pending (any_pending),
      .vector      (vec_sel)
   );

   lpm_settle #(
      .STAB_CYCLES (STAB_CYCLES)
   ) u_settle (
      .clock (clock),
      .rst_n (rst_n),
      .start (settle_start),
      .done  (settle_done)
   );

   // apb strobes, zero wait state
   assign wr      = psel && penable && pwrite;
   assign rd      = psel && !penable && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // wake conditions per mode
   assign wake_wait = any_pending || break_irq || ext_irq;
   assign wake_stop = ext_irq || break_irq || pending[1];
   assign stop_ok   = stop_instr && config_bits[lpm_pkg::CFG_STOP_EN];
   assign settle_start = (state == lpm_pkg::LPM_STOP) && wake_stop;

   // mode sequencing and side effects
   always_comb begin
      next_state       = state;
      next_config_bits = config_bits;
      next_pll_ctrl    = pll_ctrl;
      next_mask        = interrupt_mask;
      next_bw          = break_during_wait_flag;
      next_abort       = 1'b0;
      next_presc_clr   = 1'b0;
      next_cop_clr     = 1'b0;
      next_wake        = 1'b0;
      next_vector      = vector;
      if (wr && paddr == lpm_pkg::OFF_CONFIG)
         next_config_bits = pwdata[3:0];
      if (wr && paddr == lpm_pkg::OFF_PLL_CTRL)
         next_pll_ctrl = pwdata[1:0];
      if (wr && paddr == lpm_pkg::OFF_COMMAND) begin
         if (pwdata[lpm_pkg::CMD_BW_CLEAR])
            next_bw = 1'b0;
         next_cop_clr = pwdata[lpm_pkg::CMD_COP_CLEAR];
      end
      if (vector_taken)
         next_mask = 1'b1;
      unique case (state)
         lpm_pkg::LPM_RUN: begin
            if (stop_ok) begin
               next_state     = lpm_pkg::LPM_STOP;
               next_mask      = 1'b0;
               next_abort     = 1'b1;
               next_presc_clr = 1'b1;
               next_pll_ctrl[lpm_pkg::PLL_SEL] = 1'b0;
            end else if (wait_instr) begin
               next_state = lpm_pkg::LPM_WAIT;
               next_mask  = 1'b0;
            end
         end
         lpm_pkg::LPM_WAIT: begin
            if (wake_wait) begin
               next_state  = lpm_pkg::LPM_RUN;
               next_wake   = 1'b1;
               next_vector = break_irq ? lpm_pkg::VEC_SWI : vec_sel;
               if (break_irq)
                  next_bw = 1'b1;
            end
         end
         lpm_pkg::LPM_STOP: begin
            if (wake_stop) begin
               next_state  = lpm_pkg::LPM_SETTLE;
               next_vector = break_irq ? lpm_pkg::VEC_SWI : lpm_pkg::VEC_IRQ;
               if (break_irq)
                  next_bw = 1'b1;
            end
         end
         lpm_pkg::LPM_SETTLE: begin
            if (settle_done) begin
               next_state = lpm_pkg::LPM_RUN;
               next_wake  = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state                    <= lpm_pkg::LPM_RUN;
         config_bits              <= lpm_pkg::CONFIG_RESET;
         pll_ctrl                 <= lpm_pkg::PLL_RESET;
         interrupt_mask           <= 1'b1;
         break_during_wait_flag   <= 1'b0;
         adc_abort                <= 1'b0;
         watchdog_prescaler_clear <= 1'b0;
         watchdog_counter_clear   <= 1'b0;
         wake_pulse               <= 1'b0;
         vector                   <= lpm_pkg::VEC_RESET;
      end else begin
         state                    <= next_state;
         config_bits              <= next_config_bits;
         pll_ctrl                 <= next_pll_ctrl;
         interrupt_mask           <= next_mask;
         break_during_wait_flag   <= next_bw;
         adc_abort                <= next_abort;
         watchdog_prescaler_clear <= next_presc_clr;
         watchdog_counter_clear   <= next_cop_clr;
         wake_pulse               <= next_wake;
         vector                   <= next_vector;
      end
   end

   // clock and module enables from mode
   always_comb begin
      logic in_stop;
      logic osc_run;
      in_stop = (state == lpm_pkg::LPM_STOP) || (state == lpm_pkg::LPM_SETTLE);
      osc_run = config_bits[lpm_pkg::CFG_OSC_RUN];
      cpu_clock_en      = (state == lpm_pkg::LPM_RUN);
      bus_clock_en      = !in_stop || osc_run;
      osc_enable        = !in_stop || osc_run || state == lpm_pkg::LPM_SETTLE;
      pll_enable        = pll_ctrl[lpm_pkg::PLL_PWR] && !in_stop;
      crystal_clock_en  = osc_enable;
      core_clock_en     = !in_stop;
      clockgen_int_en   = !in_stop;
      core_from_vco     = pll_ctrl[lpm_pkg::PLL_SEL] && pll_enable;
      adc_enable        = !in_stop;
      watchdog_clock_en = !in_stop;
      lvi_enable        = !(state == lpm_pkg::LPM_WAIT && config_bits[lpm_pkg::CFG_LVI_OFF]);
      timebase_enable   = !(state == lpm_pkg::LPM_WAIT && config_bits[lpm_pkg::CFG_TBM_OFF])
                          && (!in_stop || osc_run);
      break_enable      = !in_stop;
   end

   // register read mux
   always_comb begin
      next_prdata = prdata;
      if (rd) begin
         unique case (paddr)
            lpm_pkg::OFF_CONFIG:    next_prdata = {28'h0, config_bits};
            lpm_pkg::OFF_PLL_CTRL:  next_prdata = {30'h0, pll_ctrl};
            lpm_pkg::OFF_STATUS:    next_prdata = {23'h0, break_during_wait_flag,
                                                   interrupt_mask, 3'h0, state};
            lpm_pkg::OFF_IRQ_ONE:   next_prdata = {24'h0, pending[6:1], 2'h0};
            lpm_pkg::OFF_IRQ_TWO:   next_prdata = {24'h0, pending[14:7]};
            lpm_pkg::OFF_IRQ_THREE: next_prdata = {30'h0, pending[16:15]};
            lpm_pkg::OFF_VECTOR:    next_prdata = {16'h0, vector};
            default:                next_prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         prdata <= 32'h0;
      else
         prdata <= next_prdata;
   end
endmodule

// ---- dv/lpm_control_assertions.sv ----
// concurrent checks on the low power mode controller ports
`timescale 1ns/10ps
module lpm_control_assertions #(
   parameter int STAB_CYCLES = 8
) (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        wait_instr,
   input wire logic        stop_instr,
   input wire logic        ext_irq,
   input wire logic        break_irq,
   input wire logic        vector_taken,
   input wire logic        cpu_clock_en,
   input wire logic        bus_clock_en,
   input wire logic        osc_enable,
   input wire logic        pll_enable,
   input wire logic        crystal_clock_en,
   input wire logic        core_clock_en,
   input wire logic        clockgen_int_en,
   input wire logic        core_from_vco,
   input wire logic        adc_enable,
   input wire logic        adc_abort,
   input wire logic        watchdog_clock_en,
   input wire logic        interrupt_mask,
   input wire logic        break_during_wait_flag,
   input wire logic        wake_pulse,
   input wire logic [15:0] vector
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   // wait entry gates only the cpu clock and opens the mask
   wait_entry_a: assert property (cpu_clock_en && wait_instr && !stop_instr |=>
      !cpu_clock_en && bus_clock_en && !interrupt_mask) else $error("wait entry wrong");
   // interrupt exit from wait restarts the cpu with the mask still clear
   wait_exit_a: assert property (cpu_clock_en && wait_instr && !stop_instr ##1
      (ext_irq && !cpu_clock_en) |-> ##[1:2] (cpu_clock_en && !interrupt_mask))
      else $error("wait exit wrong");
   // stop entry side effects
   stop_entry_a: assert property ($rose(adc_abort) |-> ##[0:1]
      (!cpu_clock_en && !adc_enable && !pll_enable && !core_from_vco && !interrupt_mask &&
      !watchdog_clock_en)) else $error("stop entry wrong");
   // bus clock loss in stop takes all clock generator outputs down
   stop_clocks_a: assert property ($fell(bus_clock_en) |-> !osc_enable &&
      !pll_enable && !crystal_clock_en && !core_clock_en && !clockgen_int_en)
      else $error("stop clocks on");
   // running cpu implies bus, adc and watchdog clocks
   run_clocks_a: assert property (cpu_clock_en |-> bus_clock_en && adc_enable &&
      watchdog_clock_en) else $error("run clocks off");
   // vector fetch stays on an even address inside the table
   vec_range_a: assert property (!vector[0] && vector >= 16'hffdc)
      else $error("vector outside table");
   // wake pulse lasts one cycle and comes with the cpu clock
   wake_once_a: assert property (wake_pulse |-> ##[0:1] cpu_clock_en ##1 !wake_pulse)
      else $error("wake pulse wrong");
   // break in full stop sets the break flag
   brk_stop_a: assert property (!bus_clock_en && !cpu_clock_en && break_irq |->
      ##[1:2] break_during_wait_flag) else $error("break flag not set");
   // vector fetch sets the mask again
   mask_set_a: assert property (vector_taken |=> interrupt_mask)
      else $error("mask not set");
endmodule
bind lpm_control lpm_control_assertions #(.STAB_CYCLES(STAB_CYCLES)) u_chk (
   .clock(clock), .resetn(resetn), .wait_instr(wait_instr), .stop_instr(stop_instr),
   .ext_irq(ext_irq), .break_irq(break_irq), .vector_taken(vector_taken),
   .cpu_clock_en(cpu_clock_en), .bus_clock_en(bus_clock_en), .osc_enable(osc_enable),
   .pll_enable(pll_enable), .crystal_clock_en(crystal_clock_en),
   .core_clock_en(core_clock_en), .clockgen_int_en(clockgen_int_en),
   .core_from_vco(core_from_vco), .adc_enable(adc_enable), .adc_abort(adc_abort),
   .watchdog_clock_en(watchdog_clock_en), .interrupt_mask(interrupt_mask),
   .break_during_wait_flag(break_during_wait_flag), .wake_pulse(wake_pulse),
   .vector(vector));

// ---- dv/tb.sv ----
// register and mode sequence testbench for the low power mode controller
`timescale 1ns/10ps
module tb;
   localparam int STAB = 8;
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        wait_instr = 1'b0, stop_instr = 1'b0, swi_req = 1'b0;
   logic [16:1] irq_source = 16'h0;
   logic        break_irq = 1'b0, ext_irq = 1'b0, vector_taken = 1'b0;
   logic        pready, pslverr, cpu_clk, bus_clk, osc, pll, xtal, core, cgint, vco;
   logic        adc, abrt, wdg, wpre, wclr, low_voltage_inhibit, tbm, brk, mask, bflag, wake;
   logic [15:0] vector;
   int          err_total = 0;
   int          n_checks = 0;
   lpm_control #(.STAB_CYCLES(STAB)) dut (
      .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .wait_instr(wait_instr), .stop_instr(stop_instr), .swi_req(swi_req),
      .irq_source(irq_source), .break_irq(break_irq), .ext_irq(ext_irq),
      .vector_taken(vector_taken), .cpu_clock_en(cpu_clk), .bus_clock_en(bus_clk),
      .osc_enable(osc), .pll_enable(pll), .crystal_clock_en(xtal), .core_clock_en(core),
      .clockgen_int_en(cgint), .core_from_vco(vco), .adc_enable(adc), .adc_abort(abrt),
      .watchdog_clock_en(wdg), .watchdog_prescaler_clear(wpre),
      .watchdog_counter_clear(wclr), .lvi_enable(low_voltage_inhibit), .timebase_enable(tbm),
      .break_enable(brk), .interrupt_mask(mask), .break_during_wait_flag(bflag),
      .wake_pulse(wake), .vector(vector));
   // clock generator
   always #20 clock = ~clock;
   // compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      q = prdata;
      chk("pslverr", 32'h0, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge, so a following setup never reassigns psel in this step
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   // one cycle wait (s=0) or stop (s=1) request
   task automatic ins(input logic s);
      stop_instr <= s;
      wait_instr <= !s;
      @(posedge clock);
      stop_instr <= 1'b0;
      wait_instr <= 1'b0;
   endtask
   // wait for the wake pulse, a missing pulse counts as a mismatch
   task automatic wait_wake(input string nm);
      int n;
      n = 0;
      while (wake !== 1'b1 && n < 60) begin
         @(posedge clock);
         n++;
      end
      chk(nm, 32'h1, {31'h0, wake});
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard
   initial begin
      #(40 * 5000);
      err_total++;
      close_out();
   end
   // test sequence
   initial begin
      int n;
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      repeat (3) @(posedge clock);
      chk("reset_vector", 32'hfffe, {16'h0, vector});
      rd(lpm_pkg::OFF_STATUS, 32'h81, "status");
      rd(lpm_pkg::OFF_CONFIG, 32'h0, "config");
      rd(lpm_pkg::OFF_PLL_CTRL, 32'h2, "pll_ctrl");
      rd(lpm_pkg::OFF_IRQ_TWO, 32'h0, "flags_two_rst");
      irq_source <= 16'hffff;
      repeat (2) @(posedge clock);
      rd(lpm_pkg::OFF_IRQ_ONE, 32'hfc, "flags_one");
      rd(lpm_pkg::OFF_IRQ_TWO, 32'hfe, "flags_two");
      rd(lpm_pkg::OFF_IRQ_THREE, 32'h3, "flags_three");
      rd(8'h20, 32'h0, "unmapped");
      irq_source <= 16'h0;
      ins(1'b1);
      @(posedge clock);
      chk("stop_refused", 32'h1, {31'h0, cpu_clk});
      $display("test reset and registers done");
      wr(lpm_pkg::OFF_CONFIG, 32'hc);
      for (int i = 1; i <= 16; i++) begin
         if (i == lpm_pkg::RESERVED_SRC) continue;
         ins(1'b0);
         irq_source[i] <= 1'b1;
         ext_irq <= (i == 1);
         @(posedge clock);
         chk("wait_clk", 32'h9d,
             {23'h0, cpu_clk, bus_clk, low_voltage_inhibit, tbm, adc, core, wdg, mask, brk});
         wait_wake("wake_seen");
         chk("wake_vector", 32'hfffc - 32'(2 * i), {16'h0, vector});
         chk("wake_mask", 32'h0, {31'h0, mask});
         irq_source <= 16'h0;
         ext_irq <= 1'b0;
         vector_taken <= 1'b1;
         @(posedge clock);
         vector_taken <= 1'b0;
      end
      ins(1'b0);
      irq_source[3] <= 1'b1;
      irq_source[12] <= 1'b1;
      wait_wake("wake_prio");
      chk("priority_vector", 32'hfff6, {16'h0, vector});
      irq_source <= 16'h0;
      ins(1'b0);
      swi_req <= 1'b1;
      wait_wake("wake_swi");
      chk("swi_vector", 32'hfffc, {16'h0, vector});
      swi_req <= 1'b0;
      $display("test wait vectors done");
      wr(lpm_pkg::OFF_PLL_CTRL, 32'h3);
      wr(lpm_pkg::OFF_CONFIG, 32'h1);
      chk("vco_select", 32'h1, {31'h0, vco});
      ins(1'b1);
      @(posedge clock);
      chk("stop_clk", 32'h0,
          {20'h0, cpu_clk, bus_clk, osc, pll, xtal, core, cgint, adc, wdg, mask, brk, vco});
      chk("stop_pulses", 32'h3, {30'h0, abrt, wpre});
      break_irq <= 1'b1;
      n = 0;
      while (cpu_clk !== 1'b1 && n < 60) begin
         @(posedge clock);
         n++;
      end
      break_irq <= 1'b0;
      chk("settle_len", 32'h1, {31'h0, n >= STAB && n <= STAB + 5});
      chk("break_vector", 32'hfffc, {16'h0, vector});
      rd(lpm_pkg::OFF_PLL_CTRL, 32'h2, "pll_select");
      rd(lpm_pkg::OFF_STATUS, 32'h101, "status_brk");
      wr(lpm_pkg::OFF_COMMAND, 32'h3);
      chk("cop_clear", 32'h1, {31'h0, wclr});
      @(posedge clock);
      chk("flag_clear", 32'h0, {31'h0, bflag});
      chk("cop_clear_end", 32'h0, {31'h0, wclr});
      $display("test stop without oscillator done");
      wr(lpm_pkg::OFF_CONFIG, 32'h3);
      ins(1'b1);
      @(posedge clock);
      chk("stop_osc", 32'h18, {26'h0, cpu_clk, bus_clk, osc, pll, adc, wdg});
      ext_irq <= 1'b1;
      wait_wake("wake_ext");
      ext_irq <= 1'b0;
      chk("ext_vector", 32'hfffa, {16'h0, vector});
      chk("ext_mask", 32'h0, {31'h0, mask});
      $display("test stop with oscillator done");
      ins(1'b0);
      @(posedge clock);
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      repeat (3) @(posedge clock);
      chk("reset_exit", 32'h3, {30'h0, cpu_clk, mask});
      $display("test reset exit done");
      close_out();
   end
endmodule
